// File: design/pao_buf2.sv
// Two-entry skid buffer carrying converted words
`timescale 1ns/1ps
`default_nettype none
module pao_buf2 #(
  parameter int WIDTH = 11
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // Elaboration check on the word width
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least one");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0]            cnt;
    logic                  rp;
    logic                  wp;
  } pao_buf_st_t;

  pao_buf_st_t st_q;
  pao_buf_st_t st_d;
  logic        push;
  logic        pop;

  assign in_ready  = (st_q.cnt != 2'h2);
  assign out_valid = (st_q.cnt != 2'h0);
  assign out_data  = st_q.mem[st_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = ~st_q.wp;
    end
    if (pop) begin
      st_d.rp = ~st_q.rp;
    end
    st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule
`default_nettype wire

// File: design/pao_pkg.sv
// Package: constants and carrier types for the pipelined converter output port
// Summary of operation
// - Inputs above the upper reference give code 3FF and inputs below the lower reference give 000.
// - A new sample is taken on each falling edge of the sample clock.
// - A sample's result appears at the outputs two sample clocks later, plus the output delay.
// - One fresh word leaves on the data pins per sample clock while converting, at fixed latency; the capture stream can lag or drop words.
// - Conversion runs only while the sample clock runs and standby is low.
// - Data outputs are driven while the output enable is low and standby is low.
// - Data outputs float whenever output enable or standby is high.
// - The output word changes only after a falling clock edge, so the old word holds past that edge.
// - In-range inputs become ten-bit words at up to the maximum sample rate.
package pao_pkg;

  localparam int          DATA_W       = 10;
  localparam int          LATENCY      = 2;
  localparam int          IN_W         = 12;
  localparam logic [9:0]  CODE_MAX     = 10'h3FF;
  localparam logic [9:0]  CODE_MIN     = 10'h000;
  localparam int          CLK_MHZ      = 100;
  localparam int          MAX_RATE_MSPS = 30;
  localparam int          WAKE_NS      = 700;
  localparam int          WAKE_CYC     = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int          TOD_NS       = 25;
  localparam int          TOD_CYC      = (TOD_NS * CLK_MHZ) / 1000;

  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic              awake;
  } pao_word_t;

endpackage

// File: design/pao_top.sv
// Top: sample capture, coding, pipeline, buffering and output drive
`timescale 1ns/1ps
`default_nettype none
module pao_top #(
  parameter int LATENCY = pao_pkg::LATENCY,
  parameter int IN_W    = pao_pkg::IN_W
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  // Sample side
  input  wire logic                      sample_clk,
  input  wire logic [IN_W-1:0]           sample_level,
  input  wire logic [IN_W-1:0]           ref_low,
  input  wire logic [IN_W-1:0]           ref_high,
  // Control pins
  input  wire logic                      standby_request,
  input  wire logic                      out_enable_n,
  // Data pins
  output logic [pao_pkg::DATA_W-1:0]     data_o,
  output logic [pao_pkg::DATA_W-1:0]     data_oe_n,
  // Capture side stream
  output logic                           word_valid,
  input  wire logic                      word_ready,
  output logic                           word_awake
);

  localparam int DW = pao_pkg::DATA_W;

  // Elaboration checks on the parameters
  if (LATENCY < 1 || LATENCY > 8) begin : g_bad_latency
    $error("LATENCY out of range");
  end
  if (IN_W < 2) begin : g_bad_in_w
    $error("IN_W too small");
  end

  typedef struct packed {
    logic [1:0]                  sclk_sync;
    logic                        sclk_prev;
    logic [1:0]                  sby_sync;
    logic [1:0]                  oen_sync;
    logic [IN_W-1:0]             lvl_s1;
    logic [IN_W-1:0]             lvl_s2;
    logic [LATENCY-1:0][DW-1:0]  pipe;
    logic [LATENCY-1:0]          pvld;
    logic [9:0]                  wake_cnt;
    logic [DW-1:0]               dout;
    logic                        drive;
  } pao_st_t;

  pao_st_t          st_q;
  pao_st_t          st_d;
  logic             fall;
  logic             converting;
  logic [DW-1:0]    code_now;
  logic             buf_in_ready;
  logic             buf_out_valid;
  pao_pkg::pao_word_t buf_in;
  pao_pkg::pao_word_t buf_out;

  // Scale a level between the references into ten bits
  function automatic logic [DW-1:0] quantize(
    input logic [IN_W-1:0] lvl,
    input logic [IN_W-1:0] lo,
    input logic [IN_W-1:0] hi
  );
    logic [IN_W+DW-1:0] num;
    logic [IN_W-1:0]    span;
    logic [IN_W+DW-1:0] q;
    num  = '0;
    span = '0;
    q    = '0;
    if (lvl >= hi) begin
      quantize = pao_pkg::CODE_MAX;
    end else if (lvl <= lo) begin
      quantize = pao_pkg::CODE_MIN;
    end else begin
      span = hi - lo;
      num  = IN_W'(lvl - lo) * (IN_W+DW)'(1 << DW);
      q    = num / (IN_W+DW)'(span);
      quantize = q[DW-1:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Edge detect and coding
  // ------------------------------------------------------------
  // Sample clock is far below core_clk, so a synchronised copy is
  // good enough to find its falling edges
  assign fall       = st_q.sclk_prev && !st_q.sclk_sync[1];
  assign converting = !st_q.sby_sync[1];
  assign code_now   = quantize(st_q.lvl_s2, ref_low, ref_high);

  assign buf_in = '{code:  st_q.pipe[LATENCY-1],
                    awake: (st_q.wake_cnt == 10'(pao_pkg::WAKE_CYC))};

  always_comb begin
    st_d = st_q;
    st_d.sclk_sync = {st_q.sclk_sync[0], sample_clk};
    st_d.sclk_prev = st_q.sclk_sync[1];
    st_d.sby_sync  = {st_q.sby_sync[0], standby_request};
    st_d.oen_sync  = {st_q.oen_sync[0], out_enable_n};
    st_d.lvl_s1    = sample_level;
    st_d.lvl_s2    = st_q.lvl_s1;
    // Wake-up tracking only flags words; the capture side decides
    if (!converting) begin
      st_d.wake_cnt = '0;
    end else if (st_q.wake_cnt != 10'(pao_pkg::WAKE_CYC)) begin
      st_d.wake_cnt = st_q.wake_cnt + 10'h001;
    end
    if (fall && converting) begin
      st_d.pipe[0] = code_now;
      st_d.pvld[0] = 1'b1;
      for (int i = 1; i < LATENCY; i++) begin
        st_d.pipe[i] = st_q.pipe[i-1];
        st_d.pvld[i] = st_q.pvld[i-1];
      end
    end
    if (!converting) begin
      st_d.pvld = '0;
    end
    // Pins only move on a falling edge, the old word holds until then;
    // they read the pipeline tail so a stalled capture side adds no latency
    if (fall && converting && st_q.pvld[LATENCY-1]) begin
      st_d.dout = st_q.pipe[LATENCY-1];
    end
    st_d.drive = !st_q.oen_sync[1] && !st_q.sby_sync[1];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.sby_sync <= 2'h3;
      st_q.oen_sync <= 2'h3;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // Word buffer
  // ------------------------------------------------------------
  // A stalled capture side keeps up to two words; beyond that the
  // newest pipeline word is dropped since the sampler cannot stop
  pao_buf2 #(
    .WIDTH     ($bits(pao_pkg::pao_word_t))
  ) u_buf (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .in_valid  (fall && converting && st_q.pvld[LATENCY-1]),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (buf_out_valid),
    .out_ready (word_ready),
    .out_data  (buf_out)
  );

  assign word_valid = buf_out_valid;
  // Stale entries of an empty buffer must not look trusted
  assign word_awake = buf_out_valid && buf_out.awake;
  assign data_o     = st_q.dout;
  assign data_oe_n  = {DW{!st_q.drive}};

endmodule
`default_nettype wire

// File: dv/pao_cap.sv
// Capture-side model: random stalls, counts trusted words
`timescale 1ns/1ps
`default_nettype none
module pao_cap (
  input wire logic   core_clk,
  input wire logic   sys_rst,
  input wire logic   word_valid,
  input wire logic   word_awake,
  output logic       word_ready,
  output logic [31:0] fresh_cnt
);
  always @(posedge core_clk) begin
    word_ready <= sys_rst ? 1'b0 : 1'($urandom);
    // Only words taken after wake-up are trusted
    if (sys_rst) fresh_cnt <= 0;
    else if (word_valid && word_ready && word_awake) fresh_cnt <= fresh_cnt + 1;
  end
endmodule
`default_nettype wire

// File: dv/pao_chk.sv
// Port checker for the converter output port
`timescale 1ns/1ps
`default_nettype none
module pao_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       sys_rst,
  // Pins
  input wire logic       sample_clk,
  input wire logic       standby_request,
  input wire logic       out_enable_n,
  input wire logic [9:0] data_o,
  input wire logic [9:0] data_oe_n,
  input wire logic       word_valid,
  input wire logic       word_awake
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Three-cycle sync lag, so a level must hold four cycles
  wire logic off_w = out_enable_n || standby_request;
  oe_off_a: assert property (off_w [*4] |-> &data_oe_n)
    else $error("pins not released");
  oe_on_a: assert property (!off_w [*4] |-> data_oe_n == '0)
    else $error("pins not driven");
  oe_lag_a: assert property (!off_w [*4] ##1 off_w |=> data_oe_n == '0)
    else $error("pins released too early");
  oe_even_a: assert property (data_oe_n == '0 || &data_oe_n)
    else $error("pin enables disagree");
  word_hold_a: assert property (sample_clk [*6] |-> $stable(data_o))
    else $error("word changed away from a fall");
  clk_stop_a: assert property (($stable(sample_clk) && !standby_request) [*8] |-> $stable(data_o))
    else $error("word changed with clock stopped");
  rst_val_a: assert property ($fell(sys_rst) |-> data_o == '0 && &data_oe_n && !word_valid)
    else $error("bad state after reset");
  wake_a: assert property (standby_request [*8] ##1 !standby_request |-> !word_awake [*8])
    else $error("word marked awake too soon");
endmodule
bind pao_top pao_chk chk (.core_clk(core_clk), .sys_rst(sys_rst), .sample_clk(sample_clk),
  .standby_request(standby_request), .out_enable_n(out_enable_n), .data_o(data_o),
  .data_oe_n(data_oe_n), .word_valid(word_valid), .word_awake(word_awake));
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 0, sys_rst = 1, sample_clk = 1, standby_request = 0, out_enable_n = 0;
  logic [11:0] sample_level = 0, ref_low = 12'h100, ref_high = 12'hF00;
  logic [9:0]  data_o, data_oe_n, last;
  logic        word_valid, word_ready, word_awake;
  logic [31:0] fresh_cnt, base;
  logic [11:0] edges [6] = '{12'h000, 12'h100, 12'h101, 12'hEFF, 12'hF00, 12'hFFF};
  int          failures = 0, checks = 0, n;
  int          q [$];
  pao_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .sample_clk(sample_clk),
    .sample_level(sample_level), .ref_low(ref_low), .ref_high(ref_high),
    .standby_request(standby_request), .out_enable_n(out_enable_n), .data_o(data_o),
    .data_oe_n(data_oe_n), .word_valid(word_valid), .word_ready(word_ready),
    .word_awake(word_awake));
  pao_cap cap (.core_clk(core_clk), .sys_rst(sys_rst), .word_valid(word_valid),
    .word_awake(word_awake), .word_ready(word_ready), .fresh_cnt(fresh_cnt));
  initial forever #5 core_clk = ~core_clk;
  initial begin
    repeat (50000) @(posedge core_clk);
    failures++;
    end_of_test();
  end
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_code(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected code at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_oe(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected enables at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  // Straight binary, clipped at both references
  function automatic logic [9:0] code_of(input int lv);
    if (lv >= int'(ref_high)) return 10'h3FF;
    if (lv <= int'(ref_low)) return 10'h000;
    return 10'((lv - int'(ref_low)) * 1024 / (int'(ref_high) - int'(ref_low)));
  endfunction
  // One sample clock period of sixteen cycles
  task automatic period(input logic [11:0] lv);
    sample_level <= lv;
    sample_clk <= 1'b0;
    q.push_back(code_of(lv));
    repeat (8) @(posedge core_clk);
    sample_clk <= 1'b1;
    repeat (4) @(posedge core_clk);
    if (q.size() > 2) begin
      last = 10'(q.pop_front());
      chk_code(data_o, last);
    end
    repeat (4) @(posedge core_clk);
  endtask
  initial begin
    void'($urandom(32'h686d7b21));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (n = 0; n < 40; n++) period(n < 6 ? edges[n] : 12'($urandom));
    chk_oe(data_oe_n, 10'h000);
    $display("stream test done");
    out_enable_n <= 1'b1;
    period(12'h800);
    chk_oe(data_oe_n, 10'h3FF);
    repeat (20) @(posedge core_clk);
    chk_code(data_o, last);
    out_enable_n <= 1'b0;
    standby_request <= 1'b1;
    q.delete();
    repeat (20) @(posedge core_clk);
    chk_oe(data_oe_n, 10'h3FF);
    $display("enable test done");
    standby_request <= 1'b0;
    base = fresh_cnt;
    repeat (10) @(posedge core_clk);
    for (n = 0; n < 12; n++) begin
      period(12'($urandom));
      // No word may be trusted inside the wake-up time
      if (n == 3) chk_code(10'(fresh_cnt - base), 10'h000);
    end
    chk_code(10'(fresh_cnt != base), 10'h001);
    $display("wake test done");
    end_of_test();
  end
endmodule
`default_nettype wire
